// ---- oidc_host.sv ----
`timescale 1ns/1ps
module oidc_host (
  oidc_link_if.host link,
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_op_i,
  input wire logic [31:0] cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic [3:0] cmd_rd_len_i,
  output logic cmd_ready_o,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  output logic done_o
);

  oidc_pkg::oidc_host_state_t state_reg;
  logic [1:0] phase_reg;
  logic [2:0] slot_reg;
  logic [2:0] nsend_reg;
  logic is_read_reg;
  logic [3:0] len_reg;
  logic [3:0] rcnt_reg;
  logic [7:0] op_reg;
  logic [31:0] addr_reg;
  logic [7:0] data_reg;
  logic ck_reg;
  logic cs_n_reg;
  logic [7:0] dq_reg;
  logic oe_reg;
  logic [7:0] dq_s1_reg;
  logic [7:0] dq_s2_reg;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire in_no_addr = (cmd_op_i == oidc_pkg::OP_WRITE_ENABLE) ||
                    (cmd_op_i == oidc_pkg::OP_WRITE_DISABLE);
  wire in_wany = (cmd_op_i == oidc_pkg::OP_WRITE_ANY);
  wire in_read = (cmd_op_i == oidc_pkg::OP_READ_ID) || (cmd_op_i == oidc_pkg::OP_READ_PARAMS) ||
                 (cmd_op_i == oidc_pkg::OP_READ_UNIQUE) ||
                 (cmd_op_i == oidc_pkg::OP_READ_STATUS_ONE) ||
                 (cmd_op_i == oidc_pkg::OP_READ_STATUS_TWO) ||
                 (cmd_op_i == oidc_pkg::OP_READ_ANY);
  wire [2:0] in_nsend = in_no_addr ? oidc_pkg::SEND_NO_ADDR :
                        (in_wany ? oidc_pkg::SEND_ADDR_DATA : oidc_pkg::SEND_ADDR);
  wire accept = (state_reg == oidc_pkg::OIDC_IDLE) && cmd_valid_i;

  wire [1:0] phase_next = phase_reg + 2'h1;
  wire slot_end = (phase_reg == oidc_pkg::PHASE_LAST);
  wire [2:0] slot_next = slot_reg + 3'h1;
  wire send_done = slot_end && (slot_next == nsend_reg);

  // opcode twice, then address most significant first
  wire [7:0] tx_byte = (slot_next < 3'h2) ? op_reg :
                       (slot_next == 3'h2) ? addr_reg[31:24] :
                       (slot_next == 3'h3) ? addr_reg[23:16] :
                       (slot_next == 3'h4) ? addr_reg[15:8] :
                       (slot_next == 3'h5) ? addr_reg[7:0] :
                       data_reg;
  // One edge after the rise, the byte launched on the previous rise has passed both return flops
  wire sample = (state_reg == oidc_pkg::OIDC_READ) && (phase_reg == oidc_pkg::PHASE_SAMPLE);
  wire [3:0] rcnt_next = rcnt_reg + 4'h1;

  // ----------------------------------------------------------------
  // Return data synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
    end else begin
      dq_s1_reg <= link.dq;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer; link clock is the divider's top phase bit
  // ----------------------------------------------------------------
  // data changes at low phase, stable across the rise
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= oidc_pkg::OIDC_IDLE;
      phase_reg <= oidc_pkg::PHASE_RESET;
      slot_reg <= 3'h0;
      nsend_reg <= oidc_pkg::SEND_ADDR;
      is_read_reg <= 1'b0;
      len_reg <= 4'h0;
      rcnt_reg <= 4'h0;
      op_reg <= 8'h00;
      addr_reg <= 32'h0000_0000;
      data_reg <= 8'h00;
      ck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      dq_reg <= 8'h00;
      oe_reg <= 1'b0;
      cmd_ready_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
      done_o <= 1'b0;
    end else begin
      rd_valid_o <= 1'b0;
      done_o <= 1'b0;
      cmd_ready_o <= 1'b0;
      case (state_reg)
        oidc_pkg::OIDC_IDLE: begin
          cmd_ready_o <= !cmd_valid_i;
          if (accept) begin
            op_reg <= cmd_op_i;
            addr_reg <= cmd_addr_i;
            data_reg <= cmd_data_i;
            len_reg <= cmd_rd_len_i;
            nsend_reg <= in_nsend;
            is_read_reg <= in_read;
            slot_reg <= 3'h0;
            rcnt_reg <= 4'h0;
            phase_reg <= oidc_pkg::PHASE_RESET;
            cs_n_reg <= 1'b0;
            dq_reg <= cmd_op_i;
            oe_reg <= 1'b1;
            state_reg <= oidc_pkg::OIDC_SEND;
          end
        end
        oidc_pkg::OIDC_SEND: begin
          phase_reg <= phase_next;
          ck_reg <= phase_next[1];
          if (slot_end) begin
            slot_reg <= slot_next;
            dq_reg <= tx_byte;
          end
          if (send_done) begin
            oe_reg <= 1'b0;
            // SDR only, so no falling edge bytes
            if (is_read_reg && (len_reg != 4'h0)) begin
              state_reg <= oidc_pkg::OIDC_READ;
            end else begin
              state_reg <= oidc_pkg::OIDC_FINISH;
            end
          end
        end
        oidc_pkg::OIDC_READ: begin
          phase_reg <= phase_next;
          ck_reg <= phase_next[1];
          if (sample) begin
            rd_valid_o <= 1'b1;
            rd_data_o <= dq_s2_reg;
            rcnt_reg <= rcnt_next;
            if (rcnt_next == len_reg) begin
              state_reg <= oidc_pkg::OIDC_FINISH;
            end
          end
        end
        oidc_pkg::OIDC_FINISH: begin
          ck_reg <= 1'b0;
          cs_n_reg <= 1'b1;
          oe_reg <= 1'b0;
          done_o <= 1'b1;
          state_reg <= oidc_pkg::OIDC_IDLE;
        end
        default: begin
          state_reg <= oidc_pkg::OIDC_IDLE;
          cs_n_reg <= 1'b1;
          ck_reg <= 1'b0;
          oe_reg <= 1'b0;
        end
      endcase
    end
  end

  assign link.ck = ck_reg;
  assign link.cs_n = cs_n_reg;
  assign link.h_dq = dq_reg;
  assign link.h_oe = oe_reg;

endmodule // oidc_host

// ---- oidc_pkg.sv ----
package oidc_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_ID = 8'h9F;
  localparam logic [7:0] OP_READ_PARAMS = 8'h5A;
  localparam logic [7:0] OP_READ_UNIQUE = 8'h4C;
  localparam logic [7:0] OP_READ_STATUS_ONE = 8'h05;
  localparam logic [7:0] OP_READ_STATUS_TWO = 8'h07;
  localparam logic [7:0] OP_READ_ANY = 8'h65;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_ANY = 8'h71;

  // ----------------------------------------------------------------
  // Frame byte positions
  // ----------------------------------------------------------------
  localparam logic [2:0] CNT_OP_SECOND = 3'h1;
  localparam logic [2:0] CNT_ADDR_LAST = 3'h5;
  localparam logic [2:0] CNT_DATA = 3'h6;
  localparam logic [2:0] CNT_MAX = 3'h7;
  localparam logic [2:0] SEND_NO_ADDR = 3'h2;
  localparam logic [2:0] SEND_ADDR = 3'h6;
  localparam logic [2:0] SEND_ADDR_DATA = 3'h7;

  // ----------------------------------------------------------------
  // Device state and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_ONE_WEL_MASK = 8'h02;
  localparam logic WEL_RESET = 1'b0;
  localparam logic [7:0] STATUS_TWO_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int REG_DEPTH = 16;
  localparam int REG_AW = 4;
  localparam logic [63:0] PARAM_TABLE = 64'h0000_FF01_5044_4653;
  localparam logic [7:0] PARAM_BLANK = 8'hFF;

  // ----------------------------------------------------------------
  // Host clock divider: four reference cycles per link clock period
  // ----------------------------------------------------------------
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [1:0] PHASE_SAMPLE = 2'h2;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  typedef enum logic [3:0] {
    OIDC_IDLE = 4'b0001,
    OIDC_SEND = 4'b0010,
    OIDC_READ = 4'b0100,
    OIDC_FINISH = 4'b1000
  } oidc_host_state_t;

endpackage

// ---- oidc_link_if.sv ----
`timescale 1ns/1ps
interface oidc_link_if;
  logic ck;
  logic cs_n;
  logic [7:0] h_dq;
  logic h_oe;
  logic [7:0] d_dq;
  logic d_oe;
  logic [7:0] dq;

  // Host wins an overlap; the wire reads zero when undriven
  assign dq = h_oe ? h_dq : (d_oe ? d_dq : 8'h00);

  modport host (output ck, output cs_n, output h_dq, output h_oe, input dq);
  modport device (input ck, input cs_n, input dq, output d_dq, output d_oe);
endinterface

// ---- oidc_device.sv ----
`timescale 1ns/1ps
module oidc_device #(
  // Arbitrary value
  parameter logic [31:0] ID_CODE = 32'h0403_0201,
  // Arbitrary value
  parameter logic [63:0] UNIQUE_CODE = 64'h1122_3344_5566_7788
) (
  oidc_link_if.device link,
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  output logic wel_o,
  output logic wr_done_o
);

  // ----------------------------------------------------------------
  // Link domain state
  // ----------------------------------------------------------------
  logic [2:0] cnt_reg;
  logic [7:0] op_reg;
  logic bad_reg;
  logic [31:0] addr_reg;
  logic [7:0] dout_reg;
  logic doe_reg;
  logic wel_reg;
  logic wr_tog_reg;
  logic [7:0] regs_mem [oidc_pkg::REG_DEPTH];

  // Chip select high ends the frame even with the clock stopped
  wire frame_rst_b = rst_b_i & ~link.cs_n;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire op_is_id = (op_reg == oidc_pkg::OP_READ_ID);
  wire op_is_params = (op_reg == oidc_pkg::OP_READ_PARAMS);
  wire op_is_unique = (op_reg == oidc_pkg::OP_READ_UNIQUE);
  wire op_is_sr1 = (op_reg == oidc_pkg::OP_READ_STATUS_ONE);
  wire op_is_sr2 = (op_reg == oidc_pkg::OP_READ_STATUS_TWO);
  wire op_is_rany = (op_reg == oidc_pkg::OP_READ_ANY);
  wire op_is_wren = (op_reg == oidc_pkg::OP_WRITE_ENABLE);
  wire op_is_wrdis = (op_reg == oidc_pkg::OP_WRITE_DISABLE);
  wire op_is_wany = (op_reg == oidc_pkg::OP_WRITE_ANY);
  wire op_is_read = op_is_id | op_is_params | op_is_unique | op_is_sr1 | op_is_sr2 | op_is_rany;
  wire op_known = op_is_read | op_is_wren | op_is_wrdis | op_is_wany;

  wire at_op_second = (cnt_reg == oidc_pkg::CNT_OP_SECOND);
  wire in_addr = (cnt_reg > oidc_pkg::CNT_OP_SECOND) && (cnt_reg <= oidc_pkg::CNT_ADDR_LAST);
  // both opcode copies must match a known code
  wire op_second_bad = (link.dq != op_reg) || !op_known;
  wire op_second_ok = at_op_second && !op_second_bad;

  // enable takes effect on the second copy
  wire wel_set = op_second_ok && op_is_wren;
  // disable takes effect on the second copy
  wire wel_clr = op_second_ok && op_is_wrdis;

  wire [31:0] addr_next = {addr_reg[23:0], link.dq};
  wire start_read = (cnt_reg == oidc_pkg::CNT_ADDR_LAST) && !bad_reg && op_is_read;
  wire [31:0] rd_addr = start_read ? addr_next : addr_reg;
  wire [31:0] rd_addr_inc = rd_addr + 32'h0000_0001;

  // register write needs the latch set
  wire wr_en = (cnt_reg == oidc_pkg::CNT_DATA) && !bad_reg && op_is_wany && wel_reg;
  wire [oidc_pkg::REG_AW-1:0] wr_idx = addr_reg[oidc_pkg::REG_AW-1:0];

  wire [2:0] cnt_next = (cnt_reg == oidc_pkg::CNT_MAX) ? cnt_reg : cnt_reg + 3'h1;

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  // identification bytes indexed by address
  wire [7:0] id_byte = ID_CODE[{rd_addr[1:0], 3'h0} +: 8];
  // parameter table, blank beyond its end
  wire param_in_table = (rd_addr[31:3] == 29'h0000_0000);
  wire [7:0] param_byte = param_in_table ? oidc_pkg::PARAM_TABLE[{rd_addr[2:0], 3'h0} +: 8]
                                         : oidc_pkg::PARAM_BLANK;
  // eight bytes of the unique value, then they repeat
  wire [7:0] unique_byte = UNIQUE_CODE[{rd_addr[2:0], 3'h0} +: 8];
  // status one shows the latch on bit 1 only, through STATUS_ONE_WEL_MASK
  wire [7:0] sr1_byte = wel_reg ? oidc_pkg::STATUS_ONE_WEL_MASK : 8'h00;
  // status two has no live bits in this block
  wire [7:0] sr2_byte = oidc_pkg::STATUS_TWO_RESET;
  // register file, low address bits only, so it aliases
  wire [7:0] any_byte = regs_mem[rd_addr[oidc_pkg::REG_AW-1:0]];

  wire [7:0] rd_byte = op_is_id ? id_byte :
                       op_is_params ? param_byte :
                       op_is_unique ? unique_byte :
                       op_is_sr1 ? sr1_byte :
                       op_is_sr2 ? sr2_byte :
                       any_byte;

  // ----------------------------------------------------------------
  // Frame sequencer, cleared between frames
  // ----------------------------------------------------------------
  // one byte per rising edge of the link clock
  always_ff @(posedge link.ck or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      cnt_reg <= 3'h0;
      op_reg <= 8'h00;
      bad_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      dout_reg <= 8'h00;
      doe_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      if (cnt_reg == 3'h0) begin
        op_reg <= link.dq;
      end
      // a bad frame is dropped for its remainder
      if (at_op_second && op_second_bad) begin
        bad_reg <= 1'b1;
      end
      // address arrives most significant byte first
      if (in_addr) begin
        addr_reg <= addr_next;
      end else if (doe_reg) begin
        addr_reg <= rd_addr_inc;
      end
      // Data leaves on the edge that takes the last address byte
      if (start_read || doe_reg) begin
        doe_reg <= 1'b1;
        dout_reg <= rd_byte;
      end
      if (start_read) begin
        addr_reg <= rd_addr_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Persistent link domain state
  // ----------------------------------------------------------------
  always_ff @(posedge link.ck or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wel_reg <= oidc_pkg::WEL_RESET;
      wr_tog_reg <= 1'b0;
    end else begin
      if (wel_set) begin
        wel_reg <= 1'b1;
      end else if (wel_clr) begin
        wel_reg <= 1'b0;
      end
      if (wr_en) begin
        wr_tog_reg <= ~wr_tog_reg;
      end
    end
  end

  // one data byte updates the addressed register
  generate
    for (genvar i = 0; i < oidc_pkg::REG_DEPTH; i++) begin : g_reg
      always_ff @(posedge link.ck or negedge rst_b_i) begin
        if (!rst_b_i) begin
          regs_mem[i] <= oidc_pkg::REG_RESET;
        end else if (wr_en && (wr_idx == (oidc_pkg::REG_AW)'(i))) begin
          regs_mem[i] <= link.dq;
        end
      end
    end
  endgenerate

  assign link.d_dq = dout_reg;
  assign link.d_oe = doe_reg;

  // ----------------------------------------------------------------
  // Crossing into the reference domain
  // ----------------------------------------------------------------
  logic wel_s1_reg;
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;

  // Level through two flops, write event as a toggle
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wel_s1_reg <= oidc_pkg::WEL_RESET;
      wel_o <= oidc_pkg::WEL_RESET;
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
      wr_done_o <= 1'b0;
    end else begin
      wel_s1_reg <= wel_reg;
      wel_o <= wel_s1_reg;
      tog_s1_reg <= wr_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
      wr_done_o <= tog_s2_reg ^ tog_s3_reg;
    end
  end

endmodule // oidc_device

// ---- oidc_properties.sv ----
`timescale 1ns/1ps
module oidc_properties (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic [7:0] h_dq,
  input wire logic h_oe,
  input wire logic [7:0] d_dq,
  input wire logic d_oe,
  input wire logic [7:0] dq
);
  default clocking dflt_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // ----------------------------------------------------------------
  // Link edge tracking
  // ----------------------------------------------------------------
  // Counts rises seen by the device; saturates so long reads stay legal
  logic ck_reg;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] op_reg;
  wire rise_w = ck && !ck_reg;
  assign cnt_next = cs_n ? 4'h0 : ((rise_w && cnt_reg != 4'hF) ? cnt_reg + 4'h1 : cnt_reg);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ck_reg <= 1'b0;
      cnt_reg <= 4'h0;
      op_reg <= 8'h00;
    end else begin
      ck_reg <= ck;
      cnt_reg <= cnt_next;
      if (rise_w && cnt_reg == 4'h0) op_reg <= dq;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  idle_clock_low_a: assert property (cs_n |-> !ck)
    else $error("link clock moved outside a frame");
  frame_open_a: assert property ($fell(cs_n) |-> h_oe && !ck ##2 rise_w)
    else $error("frame did not open with host driving");
  opcode_repeat_a: assert property (rise_w && cnt_reg == 4'h1 |-> dq == op_reg)
    else $error("second opcode byte differs from first");
  host_byte_hold_a: assert property (h_oe && ck && ck_reg |-> $stable(h_dq))
    else $error("host data moved while link clock high");
  clock_shape_a: assert property ($rose(ck) |=> ck ##1 !ck)
    else $error("link clock high phase not two cycles");
  frame_length_a: assert property ($rose(cs_n) |-> cnt_reg inside {4'h2, [4'h6:4'hF]})
    else $error("frame ended with a partial address");
  read_turn_a: assert property ($rose(d_oe) |-> rise_w && cnt_reg == 4'h5 ##2 !h_oe)
    else $error("device drove before the sixth byte");
  read_hold_a: assert property (d_oe && ck && ck_reg |-> $stable(d_dq))
    else $error("device data moved while link clock high");
  device_release_a: assert property (d_oe |-> !cs_n)
    else $error("device drives with chip select high");
endmodule // oidc_properties

// ---- octal_id_register_cmd_decoder_bench.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
  checked++; \
  if ((gt) !== (ex)) begin \
    n_mismatch++; \
    $display("BAD %s exp %0h got %0h", nm, ex, gt); \
  end \
end
module octal_id_register_cmd_decoder_bench;
  localparam logic [31:0] ID_V = 32'hA4B3_C2D1;
  localparam logic [63:0] UID_V = 64'h8F7E_6D5C_4B3A_2918;
  logic clk;
  logic rst_b;
  logic cmd_valid;
  logic [7:0] cmd_op;
  logic [31:0] cmd_addr;
  logic [7:0] cmd_data;
  logic [3:0] cmd_len;
  logic cmd_ready, rd_valid, done, wel, wr_done, wel_b, wr_done_b;
  logic [7:0] rd_data;
  logic [7:0] rd_q [16];
  int n_rd;
  int n_wr;
  int n_wr_b;
  int n_mismatch;
  int checked;

  oidc_link_if link ();
  oidc_link_if link_b ();
  oidc_host u_oidc_host (.link(link.host), .ref_clk_i(clk), .rst_b_i(rst_b),
    .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
    .cmd_rd_len_i(cmd_len), .cmd_ready_o(cmd_ready), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .done_o(done));
  oidc_device #(.ID_CODE(ID_V), .UNIQUE_CODE(UID_V)) u_oidc_device (.link(link.device),
    .ref_clk_i(clk), .rst_b_i(rst_b), .wel_o(wel), .wr_done_o(wr_done));
  // Second device faces a bench driver that breaks the opcode pairing
  oidc_device u_oidc_device_b (.link(link_b.device), .ref_clk_i(clk), .rst_b_i(rst_b),
    .wel_o(wel_b), .wr_done_o(wr_done_b));
  oidc_properties u_oidc_properties (.ref_clk_i(clk), .rst_b_i(rst_b), .ck(link.ck),
    .cs_n(link.cs_n), .h_dq(link.h_dq), .h_oe(link.h_oe), .d_dq(link.d_dq),
    .d_oe(link.d_oe), .dq(link.dq));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (wr_done === 1'b1) n_wr++;
    if (wr_done_b === 1'b1) n_wr_b++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic do_cmd(input logic [7:0] op, input logic [31:0] addr,
                        input logic [7:0] data, input logic [3:0] len);
    int i;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= addr;
    cmd_data <= data;
    cmd_len <= len;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n_rd = 0;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      #1;
      if (rd_valid === 1'b1) begin
        rd_q[n_rd] = rd_data;
        n_rd++;
      end
      if (done === 1'b1) break;
    end
    `CHK("done", 1'b1, done)
  endtask

  task automatic rd(input logic [7:0] op, input logic [31:0] addr, input logic [3:0] len,
                    input logic [63:0] ex);
    int j;
    do_cmd(op, addr, 8'h00, len);
    `CHK("count", int'(len), n_rd)
    for (j = 0; j < len; j++) `CHK("byte", ex[8*j+:8], rd_q[j])
  endtask

  // Link clock of the second pair: 80 ns, stands still between frames
  task automatic lsend(input logic [55:0] seq, input int n);
    int k;
    #13;
    link_b.cs_n = 1'b0;
    link_b.h_oe = 1'b1;
    for (k = 0; k < n; k++) begin
      link_b.h_dq = seq[8*k+:8];
      #40 link_b.ck = 1'b1;
      #40 link_b.ck = 1'b0;
    end
    #40 link_b.cs_n = 1'b1;
    link_b.h_oe = 1'b0;
    link_b.h_dq = ~link_b.h_dq;
    repeat (5) @(posedge clk);
  endtask

  initial begin
    #2000000;
    n_mismatch++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 8'h00;
    cmd_addr = 32'h0000_0000;
    cmd_data = 8'h00;
    cmd_len = 4'h0;
    link_b.ck = 1'b0;
    link_b.cs_n = 1'b1;
    link_b.h_oe = 1'b0;
    link_b.h_dq = 8'h00;
    n_wr = 0;
    n_wr_b = 0;
    n_mismatch = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("ready", 1'b1, cmd_ready)
    rd(oidc_pkg::OP_READ_STATUS_ONE, 32'h0, 4'h1, 64'h0);
    rd(oidc_pkg::OP_READ_STATUS_TWO, 32'h0, 4'h1, 64'h0);
    `CHK("wel", 1'b0, wel)
    $display("test status done");
    rd(oidc_pkg::OP_READ_ID, 32'h0, 4'h4, {32'h0, ID_V});
    rd(oidc_pkg::OP_READ_UNIQUE, 32'h0, 4'h8, UID_V);
    $display("test ident done");
    rd(oidc_pkg::OP_READ_PARAMS, 32'h0, 4'h8, oidc_pkg::PARAM_TABLE);
    rd(oidc_pkg::OP_READ_PARAMS, 32'h6, 4'h4, {48'hFFFF, oidc_pkg::PARAM_TABLE[63:48]});
    rd(oidc_pkg::OP_READ_PARAMS, 32'h0100_0000, 4'h1, 64'hFF);
    $display("test params done");
    do_cmd(oidc_pkg::OP_WRITE_ANY, 32'h3, 8'h5A, 4'h0);
    rd(oidc_pkg::OP_READ_ANY, 32'h3, 4'h1, 64'h0);
    repeat (5) @(posedge clk);
    `CHK("wr_none", 0, n_wr)
    $display("test locked done");
    do_cmd(oidc_pkg::OP_WRITE_ENABLE, 32'h0, 8'h00, 4'h0);
    repeat (4) @(posedge clk);
    `CHK("wel_set", 1'b1, wel)
    rd(oidc_pkg::OP_READ_STATUS_ONE, 32'h0, 4'h1, {56'h0, oidc_pkg::STATUS_ONE_WEL_MASK});
    do_cmd(oidc_pkg::OP_WRITE_ANY, 32'h3, 8'hA5, 4'h0);
    do_cmd(oidc_pkg::OP_WRITE_ANY, 32'h4, 8'h3C, 4'h0);
    rd(oidc_pkg::OP_READ_ANY, 32'h3, 4'h2, 64'h3CA5);
    rd(oidc_pkg::OP_READ_ANY, 32'h0, 4'h1, 64'h0);
    `CHK("wr_two", 2, n_wr)
    $display("test enable done");
    do_cmd(8'h82, 32'h0, 8'h00, 4'h0);
    repeat (4) @(posedge clk);
    `CHK("wel_kept", 1'b1, wel)
    do_cmd(oidc_pkg::OP_WRITE_DISABLE, 32'h0, 8'h00, 4'h0);
    repeat (4) @(posedge clk);
    `CHK("wel_clr", 1'b0, wel)
    rd(oidc_pkg::OP_READ_STATUS_ONE, 32'h0, 4'h1, 64'h0);
    $display("test disable done");
    lsend({40'h0, oidc_pkg::OP_READ_STATUS_TWO, oidc_pkg::OP_WRITE_ENABLE}, 2);
    `CHK("wel_b_odd", 1'b0, wel_b)
    lsend({8'h99, 8'h02, 24'h00_0000, {2{oidc_pkg::OP_WRITE_ANY}}}, 7);
    `CHK("wr_b_none", 0, n_wr_b)
    lsend({40'h0, {2{oidc_pkg::OP_WRITE_ENABLE}}}, 2);
    `CHK("wel_b_set", 1'b1, wel_b)
    lsend({8'h99, 8'h02, 24'h00_0000, {2{oidc_pkg::OP_WRITE_ANY}}}, 7);
    `CHK("wr_b_one", 1, n_wr_b)
    $display("test pairing done");
    close_out();
  end
endmodule // octal_id_register_cmd_decoder_bench
